// *** ufc_pkg.sv ***
// package: offsets, fields, reset values and timing for the uart flow-control block
package ufc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UFC_OFS_FLOW_CFG = 8'h00;
  localparam logic [7:0] UFC_OFS_XON = 8'h04;
  localparam logic [7:0] UFC_OFS_XOFF = 8'h08;
  localparam logic [7:0] UFC_OFS_MODEM = 8'h0c;
  localparam logic [7:0] UFC_OFS_TRIG = 8'h10;
  localparam logic [7:0] UFC_OFS_STATUS = 8'h14;
  // ----------------------------------------------------------------
  // flow_ctrl_cfg fields
  // ----------------------------------------------------------------
  localparam int UFC_CFG_TX_CHAR = 0;
  localparam int UFC_CFG_TX_ANY = 1;
  localparam int UFC_CFG_CTS = 2;
  localparam int UFC_CFG_DSR = 3;
  localparam int UFC_CFG_RX_MATCH = 4;
  localparam int UFC_CFG_RTS = 5;
  localparam int UFC_CFG_DTR = 6;
  localparam int UFC_CFG_HD = 7;
  // ----------------------------------------------------------------
  // modem_ctrl_reg fields (only the bits this block uses)
  // ----------------------------------------------------------------
  localparam int UFC_MCR_RX_ON = 1;
  localparam int UFC_MCR_DTR = 4;
  localparam int UFC_MCR_RTS = 5;
  // ----------------------------------------------------------------
  // trigger register fields and status fields
  // ----------------------------------------------------------------
  localparam int UFC_TRIG_HALT_LSB = 0;
  localparam int UFC_TRIG_REST_LSB = 8;
  localparam int UFC_ST_TX_STOP = 0;
  localparam int UFC_ST_RX_HOLD = 1;
  localparam int UFC_ST_HD_BUSY = 2;
  localparam int UFC_ST_RX_EN = 3;
  localparam int UFC_ST_CTS = 4;
  localparam int UFC_ST_DSR = 5;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UFC_RST_CFG = 8'h00;
  localparam logic [7:0] UFC_RST_XON = 8'h11;
  localparam logic [7:0] UFC_RST_XOFF = 8'h13;
  localparam logic [7:0] UFC_RST_MODEM = 8'h00;
  localparam logic [5:0] UFC_RST_HALT = 6'h1c;
  localparam logic [5:0] UFC_RST_REST = 6'h08;
  // ----------------------------------------------------------------
  // timing: lead time before the first bit, in bit times
  // ----------------------------------------------------------------
  localparam logic [1:0] UFC_HD_LEAD_BITS = 2'h2;
  typedef enum logic [1:0] {HD_RX, HD_LEAD, HD_TX} ufc_hd_t;
endpackage

// *** ufc_sync.sv ***
// two-flop synchroniser bank for the handshake input pins
`timescale 1ns/1ps
module ufc_sync #(
  parameter int W = 2
) (
  // clock, reset and enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else if (ce_in) begin
          meta_q[i] <= d_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign q_out = sync_q;
endmodule // ufc_sync

// *** ufc_flow.sv ***
// uart flow-control block: character and line gating, handshake outputs, half duplex
//
// Function
// - cfg bit 0 enables transmitter stop/resume character flow control.
// - cfg bit 1 enables resume-on-any-character after a stop character.
// - cfg bit 2 lets clear-to-send gate the transmitter; else ignored.
// - cfg bit 3 lets data-set-ready gate the transmitter; else ignored.
// - cfg bit 4 makes the receiver match resume and stop characters.
// - cfg bit 5: request-to-send high at halt level, low at restore level.
// - cfg bit 6: terminal-ready high at halt level, low at restore level.
// - cfg bit 7 clear gives full duplex with no transceiver steering.
// - half duplex: request-to-send and terminal-ready always opposite.
// - half duplex: raise request-to-send two bit times before first bit.
// - half duplex: drop request-to-send promptly after the last bit.
// - half duplex: software modem bits do not reach the two outputs.
// - after reset the transmitter is resumed and all flow control off.
// - writing both character flow bits set clears both.
// - combined control: stop on either, resume only when both permit.
// - half duplex: receiver off while sending unless always-on is set.
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module ufc_flow
  import ufc_pkg::*;
#(
  parameter int LVL_W = 6
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // handshake pins, cts_in and dsr_in asserted high mean the peer permits sending
  input wire logic cts_in,
  input wire logic dsr_in,
  output logic rts_out,
  output logic dtr_out,
  // receiver side
  input wire logic rx_char_valid_in,
  input wire logic [7:0] rx_char_in,
  input wire logic [LVL_W-1:0] rx_level_in,
  output logic rx_enable_out,
  output logic rx_ctrl_char_out,
  // transmitter side
  input wire logic bit_tick_in,
  input wire logic tx_data_ready_in,
  input wire logic tx_busy_in,
  output logic tx_go_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] xon_q;
  logic [7:0] xoff_q;
  logic [7:0] mcr_q;
  logic [LVL_W-1:0] halt_q;
  logic [LVL_W-1:0] rest_q;
  logic tx_stop_q;
  logic rx_hold_q;
  logic ack_q;
  logic [31:0] rdat_q;
  ufc_hd_t hd_q;
  logic [1:0] lead_q;
  logic [1:0] pins_s;
  logic cts_s;
  logic dsr_s;
  logic hd_en;
  logic wb_req;
  logic wr_lo;
  logic [7:0] cfg_wr;
  logic is_xon;
  logic is_xoff;
  logic line_ok;
  logic tx_allow;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // input pin synchronisation
  // ----------------------------------------------------------------
  // the peer must hold these for several clocks before a boundary
  ufc_sync #(.W(2)) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .d_in({dsr_in, cts_in}),
    .q_out(pins_s)
  );
  assign cts_s = pins_s[0];
  assign dsr_s = pins_s[1];
  assign hd_en = cfg_q[UFC_CFG_HD];

  // ----------------------------------------------------------------
  // wishbone slave: one wait state, ack drops after one cycle
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_in && wb_stb_in && !ack_q;
  assign wr_lo = wb_req && wb_we_in && wb_sel_in[0];
  // the illegal pair of character modes is dropped to neither
  always_comb begin
    cfg_wr = wb_dat_in[7:0];
    if (cfg_wr[UFC_CFG_TX_CHAR] && cfg_wr[UFC_CFG_TX_ANY]) begin
      cfg_wr[UFC_CFG_TX_CHAR] = 1'b0;
      cfg_wr[UFC_CFG_TX_ANY] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else if (ce_in) begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= UFC_RST_CFG;
      xon_q <= UFC_RST_XON;
      xoff_q <= UFC_RST_XOFF;
      mcr_q <= UFC_RST_MODEM;
      halt_q <= LVL_W'(UFC_RST_HALT);
      rest_q <= LVL_W'(UFC_RST_REST);
    end else if (ce_in && wr_lo) begin
      case (wb_adr_in)
        UFC_OFS_FLOW_CFG: cfg_q <= cfg_wr;
        UFC_OFS_XON: xon_q <= wb_dat_in[7:0];
        UFC_OFS_XOFF: xoff_q <= wb_dat_in[7:0];
        UFC_OFS_MODEM: mcr_q <= wb_dat_in[7:0];
        UFC_OFS_TRIG: begin
          halt_q <= wb_dat_in[UFC_TRIG_HALT_LSB +: LVL_W];
          if (wb_sel_in[1]) begin
            rest_q <= wb_dat_in[UFC_TRIG_REST_LSB +: LVL_W];
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_in)
      UFC_OFS_FLOW_CFG: rd_mux[7:0] = cfg_q;
      UFC_OFS_XON: rd_mux[7:0] = xon_q;
      UFC_OFS_XOFF: rd_mux[7:0] = xoff_q;
      UFC_OFS_MODEM: rd_mux[7:0] = mcr_q;
      UFC_OFS_TRIG: begin
        rd_mux[UFC_TRIG_HALT_LSB +: LVL_W] = halt_q;
        rd_mux[UFC_TRIG_REST_LSB +: LVL_W] = rest_q;
      end
      UFC_OFS_STATUS: begin
        rd_mux[UFC_ST_TX_STOP] = tx_stop_q;
        rd_mux[UFC_ST_RX_HOLD] = rx_hold_q;
        rd_mux[UFC_ST_HD_BUSY] = (hd_q != HD_RX);
        rd_mux[UFC_ST_RX_EN] = rx_enable_out;
        rd_mux[UFC_ST_CTS] = cts_s;
        rd_mux[UFC_ST_DSR] = dsr_s;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdat_q <= 32'h0000_0000;
    end else if (ce_in && wb_req) begin
      rdat_q <= rd_mux;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------
  // transmitter character flow control
  // ----------------------------------------------------------------
  assign is_xon = rx_char_valid_in && (rx_char_in == xon_q);
  assign is_xoff = rx_char_valid_in && (rx_char_in == xoff_q);
  // stop character wins if it equals the resume character
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_stop_q <= 1'b0;
    end else if (ce_in) begin
      if (!cfg_q[UFC_CFG_TX_CHAR] && !cfg_q[UFC_CFG_TX_ANY]) begin
        tx_stop_q <= 1'b0;
      end else if (is_xoff) begin
        tx_stop_q <= 1'b1;
      end else if (cfg_q[UFC_CFG_TX_CHAR] && is_xon) begin
        tx_stop_q <= 1'b0;
      end else if (cfg_q[UFC_CFG_TX_ANY] && rx_char_valid_in) begin
        tx_stop_q <= 1'b0;
      end
    end
  end

  // receiver flags matched characters so they can be discarded
  assign rx_ctrl_char_out = cfg_q[UFC_CFG_RX_MATCH] && (is_xon || is_xoff);

  // ----------------------------------------------------------------
  // transmit permission, taken only at a character boundary
  // ----------------------------------------------------------------
  assign line_ok = (!cfg_q[UFC_CFG_CTS] || cts_s)
    && (!cfg_q[UFC_CFG_DSR] || dsr_s);
  assign tx_allow = line_ok && !tx_stop_q;
  // a busy shifter is never interrupted; the next start waits instead
  assign tx_go_out = tx_data_ready_in && !tx_busy_in && tx_allow
    && (!hd_en || hd_q == HD_TX);

  // ----------------------------------------------------------------
  // receive fill-level hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_hold_q <= 1'b0;
    end else if (ce_in) begin
      if (rx_level_in >= halt_q) begin
        rx_hold_q <= 1'b1;
      end else if (rx_level_in <= rest_q) begin
        rx_hold_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // half-duplex transceiver sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hd_q <= HD_RX;
      lead_q <= 2'h0;
    end else if (ce_in) begin
      if (!hd_en) begin
        hd_q <= HD_RX;
        lead_q <= 2'h0;
      end else begin
        case (hd_q)
          HD_RX: begin
            lead_q <= 2'h0;
            if (tx_data_ready_in) begin
              hd_q <= HD_LEAD;
            end
          end
          HD_LEAD: begin
            if (bit_tick_in) begin
              lead_q <= lead_q + 2'h1;
              if (lead_q == UFC_HD_LEAD_BITS - 2'h1) begin
                hd_q <= HD_TX;
              end
            end
          end
          HD_TX: begin
            if (!tx_busy_in && !tx_data_ready_in) begin
              hd_q <= HD_RX;
            end
          end
          default: hd_q <= HD_RX;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (hd_en) begin
      rts_out = (hd_q != HD_RX);
      dtr_out = (hd_q == HD_RX);
    end else begin
      rts_out = cfg_q[UFC_CFG_RTS] ? rx_hold_q : mcr_q[UFC_MCR_RTS];
      dtr_out = cfg_q[UFC_CFG_DTR] ? rx_hold_q : mcr_q[UFC_MCR_DTR];
    end
  end

  assign rx_enable_out = !hd_en || mcr_q[UFC_MCR_RX_ON] || (hd_q == HD_RX);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_illegal_pair;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && wr_lo && wb_adr_in == UFC_OFS_FLOW_CFG && wb_dat_in[0] && wb_dat_in[1]
      |=> !cfg_q[UFC_CFG_TX_CHAR] && !cfg_q[UFC_CFG_TX_ANY];
  endproperty
  a_illegal_pair: assert property (p_illegal_pair) else $error("illegal pair kept");

  property p_xoff_stops;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && is_xoff && (cfg_q[UFC_CFG_TX_CHAR] || cfg_q[UFC_CFG_TX_ANY])
      |=> tx_stop_q ##0 !tx_go_out;
  endproperty
  a_xoff_stops: assert property (p_xoff_stops) else $error("stop char ignored");

  property p_cts_gate;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_q[UFC_CFG_CTS] && !cts_s |-> !tx_go_out;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("cts gate failed");

  property p_dsr_gate;
    @(posedge mclk_in) disable iff (rst_in)
    cfg_q[UFC_CFG_DSR] && !dsr_s |-> !tx_go_out;
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("dsr gate failed");

  property p_rts_halt;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && !hd_en && cfg_q[UFC_CFG_RTS] && rx_level_in >= halt_q
      |=> $changed(cfg_q) || rts_out;
  endproperty
  a_rts_halt: assert property (p_rts_halt) else $error("rts not raised at halt");

  property p_hd_opposite;
    @(posedge mclk_in) disable iff (rst_in)
    hd_en |-> rts_out != dtr_out;
  endproperty
  a_hd_opposite: assert property (p_hd_opposite) else $error("rts equals dtr");

  property p_hd_lead;
    @(posedge mclk_in) disable iff (rst_in)
    hd_en && tx_go_out |-> rts_out && lead_q == UFC_HD_LEAD_BITS;
  endproperty
  a_hd_lead: assert property (p_hd_lead) else $error("start before lead time");

  property p_hd_release;
    @(posedge mclk_in) disable iff (rst_in)
    ce_in && hd_en && hd_q == HD_TX && !tx_busy_in && !tx_data_ready_in
      |=> $changed(cfg_q) || (!rts_out && dtr_out);
  endproperty
  a_hd_release: assert property (p_hd_release) else $error("rts held after send");

  property p_rx_off;
    @(posedge mclk_in) disable iff (rst_in)
    hd_en && hd_q != HD_RX && !mcr_q[UFC_MCR_RX_ON] |-> !rx_enable_out;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver on during send");

  property p_boundary;
    @(posedge mclk_in) disable iff (rst_in)
    tx_busy_in |-> !tx_go_out;
  endproperty
  a_boundary: assert property (p_boundary) else $error("start while shifting");
endmodule // ufc_flow

// *** ufc_peer.sv ***
// far-side model: free-running baud ticks and a transmit shifter that answers tx_go
`timescale 1ns/1ps
module ufc_peer (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // transmitter handshake
  input wire logic tx_go_in,
  output logic bit_tick_out,
  output logic tx_busy_out
);
  // ----------------------------------------------------------------
  // baud ticks and shifter
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic [3:0] bits_q;
  // a bit time of four clocks keeps each character short
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign bit_tick_out = (div_q == 2'h3);
  // one character of ten bits per go, busy from the cycle after the go
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) bits_q <= 4'h0;
    else if (tx_go_in && bits_q == 4'h0) bits_q <= 4'ha;
    else if (bit_tick_out && bits_q != 4'h0) bits_q <= bits_q - 4'h1;
  end
  assign tx_busy_out = (bits_q != 4'h0);
endmodule // ufc_peer

// *** tb.sv ***
// self-checking bench for the uart flow-control block
`timescale 1ns/1ps
module tb;
  import ufc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, rts, dtr, rxen, rxctl, tick, busy, go;
  logic cts = 1'b0, dsr = 1'b0, rxv = 1'b0, rdy = 1'b0;
  logic [7:0] rxc = 8'h00;
  logic [5:0] lvl = 6'h00;
  int err_count = 0;
  int comparisons = 0;
  int t, n;
  always #20 mclk_in = ~mclk_in;
  ufc_flow u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .cts_in(cts), .dsr_in(dsr), .rts_out(rts),
    .dtr_out(dtr), .rx_char_valid_in(rxv), .rx_char_in(rxc), .rx_level_in(lvl),
    .rx_enable_out(rxen), .rx_ctrl_char_out(rxctl), .bit_tick_in(tick),
    .tx_data_ready_in(rdy), .tx_busy_in(busy), .tx_go_out(go));
  ufc_peer u_peer (.mclk_in(mclk_in), .rst_in(rst_in), .tx_go_in(go),
    .bit_tick_out(tick), .tx_busy_out(busy));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task done(input string name);
    $display("test %s finished", name);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // the master waits for ack; only the watchdog ends a dead slave
    do begin
      @(posedge mclk_in);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk(ack, 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task rx_send(input logic [7:0] c, input logic exp);
    @(posedge mclk_in);
    rxv <= 1'b1;
    rxc <= c;
    @(negedge mclk_in);
    chk(rxctl, exp);
    @(posedge mclk_in);
    rxv <= 1'b0;
  endtask
  // set cfg and pins, offer one character and see whether it is let go
  task gate(input logic [7:0] cfg, input logic [1:0] pins, input logic exp);
    logic seen;
    int k;
    wr(UFC_OFS_FLOW_CFG, {24'h0, cfg});
    @(posedge mclk_in);
    {dsr, cts} <= pins;
    repeat (4) @(posedge mclk_in);
    rdy <= 1'b1;
    seen = 1'b0;
    for (k = 0; k < 8 && !seen; k++) begin
      @(negedge mclk_in);
      seen = (go === 1'b1);
    end
    @(posedge mclk_in);
    rdy <= 1'b0;
    // busy shows from the cycle after the go, so look on the falling edge
    @(negedge mclk_in);
    while (busy !== 1'b0) begin
      @(negedge mclk_in);
    end
    chk(seen, exp);
  endtask
  task lvl_chk(input logic [5:0] l, input logic [1:0] exp);
    @(posedge mclk_in);
    lvl <= l;
    repeat (3) @(negedge mclk_in);
    chk({rts, dtr}, exp);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(UFC_OFS_FLOW_CFG, 32'h0);
    rd(UFC_OFS_XON, 32'h11);
    rd(UFC_OFS_XOFF, 32'h13);
    rd(UFC_OFS_MODEM, 32'h0);
    rd(UFC_OFS_TRIG, 32'h081c);
    rd(UFC_OFS_STATUS, 32'h08);
    wr(8'h20, 32'hff);
    rd(8'h20, 32'h0);
    wr(UFC_OFS_FLOW_CFG, 32'h03);
    rd(UFC_OFS_FLOW_CFG, 32'h0);
    done("registers");
    gate(8'h00, 2'b00, 1'b1);
    gate(8'h04, 2'b10, 1'b0);
    gate(8'h04, 2'b01, 1'b1);
    gate(8'h08, 2'b01, 1'b0);
    gate(8'h08, 2'b10, 1'b1);
    done("line gating");
    wr(UFC_OFS_FLOW_CFG, 32'h00);
    rx_send(UFC_RST_XOFF, 1'b0);
    gate(8'h00, 2'b11, 1'b1);
    wr(UFC_OFS_FLOW_CFG, 32'h01);
    rx_send(UFC_RST_XOFF, 1'b0);
    gate(8'h01, 2'b11, 1'b0);
    rx_send(8'h41, 1'b0);
    gate(8'h01, 2'b11, 1'b0);
    rx_send(UFC_RST_XON, 1'b0);
    gate(8'h01, 2'b11, 1'b1);
    wr(UFC_OFS_FLOW_CFG, 32'h02);
    rx_send(UFC_RST_XOFF, 1'b0);
    gate(8'h02, 2'b11, 1'b0);
    rx_send(8'h41, 1'b0);
    gate(8'h02, 2'b11, 1'b1);
    wr(UFC_OFS_FLOW_CFG, 32'h10);
    rx_send(UFC_RST_XOFF, 1'b1);
    rx_send(UFC_RST_XON, 1'b1);
    rx_send(8'h41, 1'b0);
    wr(UFC_OFS_FLOW_CFG, 32'h05);
    rx_send(UFC_RST_XOFF, 1'b0);
    gate(8'h05, 2'b11, 1'b0);
    rx_send(UFC_RST_XON, 1'b0);
    gate(8'h05, 2'b10, 1'b0);
    gate(8'h05, 2'b11, 1'b1);
    done("character flow");
    wr(UFC_OFS_FLOW_CFG, 32'h60);
    lvl_chk(6'h1b, 2'b00);
    lvl_chk(6'h1c, 2'b11);
    lvl_chk(6'h10, 2'b11);
    lvl_chk(6'h08, 2'b00);
    wr(UFC_OFS_FLOW_CFG, 32'h20);
    lvl_chk(6'h1c, 2'b10);
    wr(UFC_OFS_FLOW_CFG, 32'h00);
    wr(UFC_OFS_MODEM, 32'h30);
    lvl_chk(6'h00, 2'b11);
    done("handshake levels");
    wr(UFC_OFS_FLOW_CFG, 32'h80);
    lvl_chk(6'h1c, 2'b01);
    @(posedge mclk_in);
    rdy <= 1'b1;
    // the lead state is entered at the edge that samples ready
    @(negedge mclk_in);
    @(negedge mclk_in);
    chk({rts, dtr, go}, 3'b100);
    t = (tick === 1'b1);
    n = 0;
    while (go !== 1'b1 && n < 50) begin
      @(negedge mclk_in);
      if (tick === 1'b1) t++;
      n++;
    end
    chk(t, 2);
    @(posedge mclk_in);
    rdy <= 1'b0;
    @(negedge mclk_in);
    chk({rts, dtr, rxen}, 3'b100);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge mclk_in);
      n++;
    end
    @(negedge mclk_in);
    chk({rts, dtr, rxen}, 3'b011);
    done("half duplex");
    print_verdict;
  end
endmodule // tb
